/* hdl/pgw_port.sv */
// Pin function, input gating and power-down wake logic for ports A, B and C.
// Assumes an AXI4-Lite master on clk, pins asynchronous, timer and LCD signals on clk.
//
// Register access over AXI4-Lite and the placing of the registers were decided locally.
`timescale 1ns/100ps
//////////////////////////////////////////////////////////////////////////////
module pgw_port (
  input  wire logic                          clk,
  input  wire logic                          srst,
  input  wire logic [pgw_pkg::ADDR_W-1:0]    awaddr,
  input  wire logic                          awvalid,
  output logic                               awready,
  input  wire logic [31:0]                   wdata,
  input  wire logic [3:0]                    wstrb,
  input  wire logic                          wvalid,
  output logic                               wready,
  output logic [1:0]                         bresp,
  output logic                               bvalid,
  input  wire logic                          bready,
  input  wire logic [pgw_pkg::ADDR_W-1:0]    araddr,
  input  wire logic                          arvalid,
  output logic                               arready,
  output logic [31:0]                        rdata,
  output logic [1:0]                         rresp,
  output logic                               rvalid,
  input  wire logic                          rready,
  input  wire logic [pgw_pkg::A_W-1:0]       pa_in,
  output logic      [pgw_pkg::A_W-1:0]       pa_out,
  output logic      [pgw_pkg::A_W-1:0]       pa_oe,
  output logic      [pgw_pkg::A_W-1:0]       pa_pull,
  input  wire logic [pgw_pkg::B_W-1:0]       pb_in,
  output logic      [pgw_pkg::B_W-1:0]       pb_out,
  output logic      [pgw_pkg::B_W-1:0]       pb_oe,
  output logic      [pgw_pkg::B_W-1:0]       pb_pull,
  input  wire logic [pgw_pkg::C_W-1:0]       pc_in,
  output logic      [pgw_pkg::C_W-1:0]       pc_out,
  output logic      [pgw_pkg::C_W-1:0]       pc_oe,
  output logic      [pgw_pkg::C_W-1:0]       pc_pull,
  input  wire logic                          second_timer_pwm,
  input  wire logic [3:0]                    lcd_common_drive,
  input  wire logic [3:0]                    lcd_common_half,
  output logic      [3:0]                    lcd_bias_en,
  output logic      [pgw_pkg::ANA_W-1:0]     analog_chan_en,
  output logic                               crystal_en,
  output logic                               hw_reset_req,
  output logic                               ext_irq_line_zero,
  output logic                               ext_irq_line_one,
  output logic                               wake_req,
  output logic                               power_down,
  output logic                               irq
);
  typedef struct packed {
    pgw_pkg::pgw_wr_e              wst;
    logic                          awrdy;
    logic                          wrdy;
    logic                          aw_got;
    logic                          w_got;
    logic [pgw_pkg::ADDR_W-1:0]    waddr;
    logic [31:0]                   wdat;
    logic [1:0]                    bresp;
    pgw_pkg::pgw_rd_e              rst;
    logic [31:0]                   rdat;
    logic [1:0]                    rresp;
    logic [pgw_pkg::A_W-1:0]       a_out, a_dir, a_pull, a_ien;
    logic [pgw_pkg::B_W-1:0]       b_out, b_dir, b_pull, b_ien;
    logic [pgw_pkg::C_W-1:0]       c_out, c_dir, c_pull;
    logic [pgw_pkg::ANA_W-1:0]     ana;
    logic [pgw_pkg::ALT_W-1:0]     alt;
    logic [pgw_pkg::STS_W-1:0]     sts, msk;
    logic                          pdn;
    logic [pgw_pkg::PIN_W-1:0]     prev;
    logic [pgw_pkg::A_W-1:0]       pa_o, pa_e, pa_p;
    logic [pgw_pkg::B_W-1:0]       pb_o, pb_e, pb_p;
    logic [pgw_pkg::C_W-1:0]       pc_o, pc_e, pc_p;
    logic [3:0]                    bias;
    logic [pgw_pkg::ANA_W-1:0]     ana_o;
    logic                          xtal, hwrst, irq0, irq1, wake, irq;
  } pgw_port_s;

  pgw_port_s                      s;
  pgw_port_s                      nxt_s;
  logic [pgw_pkg::PIN_W-1:0]      pin_s;
  logic [pgw_pkg::PIN_W-1:0]      pin_en;
  logic [pgw_pkg::PIN_W-1:0]      gated;
  logic                           hit0;
  logic                           hit1;
  logic [pgw_pkg::STS_W-1:0]      ev;
  logic                           aw_ok;
  logic                           w_ok;
  logic [pgw_pkg::ADDR_W-1:0]     wa;
  logic [31:0]                    wd;
  logic                           rd_hit;
  logic [31:0]                    rd_val;
  logic                           rd_bad;
  logic                           wr_bad;

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and external interrupt edge detectors.
  pgw_sync #(.W(pgw_pkg::PIN_W)) u_sync (
    .clk  (clk),
    .srst (srst),
    .d    ({pc_in, pb_in, pa_in}),
    .q    (pin_s)
  );

  assign pin_en = {~({1'b0, {(pgw_pkg::C_W-1){1'b0}}} | ({pgw_pkg::C_W{s.ana[pgw_pkg::ANA_PC5]}}
                   & 6'h20)), s.b_ien, s.a_ien};
  assign gated  = pin_s & pin_en;

  pgw_edge u_edge0 (
    .clk      (clk),
    .srst     (srst),
    .sig      (gated[0]),
    .en       (s.alt[pgw_pkg::ALT_I0EN]),
    .rise_sel (s.alt[pgw_pkg::ALT_I0RI]),
    .hit      (hit0)
  );

  pgw_edge u_edge1 (
    .clk      (clk),
    .srst     (srst),
    .sig      (gated[pgw_pkg::A_W]),
    .en       (s.alt[pgw_pkg::ALT_I1EN]),
    .rise_sel (s.alt[pgw_pkg::ALT_I1RI]),
    .hit      (hit1)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Register read mux.
  always_comb begin
    rd_val = 32'h0;
    rd_bad = 1'b0;
    unique case (araddr)
      pgw_pkg::OFS_A_OUT:  rd_val[7:0] = s.a_out;
      pgw_pkg::OFS_A_DIR:  rd_val[7:0] = s.a_dir;
      pgw_pkg::OFS_A_PULL: rd_val[7:0] = s.a_pull;
      pgw_pkg::OFS_A_IEN:  rd_val[7:0] = s.a_ien;
      pgw_pkg::OFS_A_IN:   rd_val[7:0] = gated[7:0];
      pgw_pkg::OFS_B_OUT:  rd_val[6:0] = s.b_out;
      pgw_pkg::OFS_B_DIR:  rd_val[6:0] = s.b_dir;
      pgw_pkg::OFS_B_PULL: rd_val[6:0] = s.b_pull;
      pgw_pkg::OFS_B_IEN:  rd_val[6:0] = s.b_ien;
      pgw_pkg::OFS_B_IN:   rd_val[6:0] = gated[14:8];
      pgw_pkg::OFS_C_OUT:  rd_val[5:0] = s.c_out;
      pgw_pkg::OFS_C_DIR:  rd_val[5:0] = s.c_dir;
      pgw_pkg::OFS_C_PULL: rd_val[5:0] = s.c_pull;
      pgw_pkg::OFS_C_IN:   rd_val[5:0] = gated[20:15];
      pgw_pkg::OFS_ALT:    rd_val[11:0] = s.alt;
      pgw_pkg::OFS_STS:    rd_val[2:0] = s.sts;
      pgw_pkg::OFS_MSK:    rd_val[2:0] = s.msk;
      pgw_pkg::OFS_PWR:    rd_val[0] = s.pdn;
      pgw_pkg::OFS_ANA:    rd_val[9:0] = s.ana;
      default:             rd_bad = 1'b1;
    endcase
  end

  assign rd_hit = arvalid && s.rst == pgw_pkg::RD_IDLE;
  assign aw_ok  = awvalid && s.awrdy;
  assign w_ok   = wvalid && s.wrdy;
  assign wa     = aw_ok ? awaddr : s.waddr;
  assign wd     = w_ok ? wdata : s.wdat;
  assign wr_bad = !(wa inside {pgw_pkg::OFS_A_OUT, pgw_pkg::OFS_A_DIR, pgw_pkg::OFS_A_PULL,
                   pgw_pkg::OFS_A_IEN, pgw_pkg::OFS_B_OUT, pgw_pkg::OFS_B_DIR, pgw_pkg::OFS_B_PULL,
                   pgw_pkg::OFS_B_IEN, pgw_pkg::OFS_C_OUT, pgw_pkg::OFS_C_DIR, pgw_pkg::OFS_C_PULL,
                   pgw_pkg::OFS_ALT, pgw_pkg::OFS_MSK, pgw_pkg::OFS_PWR, pgw_pkg::OFS_ANA,
                   pgw_pkg::OFS_STS, pgw_pkg::OFS_A_IN, pgw_pkg::OFS_B_IN, pgw_pkg::OFS_C_IN});

  //////////////////////////////////////////////////////////////////////////////
  // Next state.
  always_comb begin
    nxt_s = s;
    ev    = '0;
    // Write channel: address and data in either order, then one response.
    if (aw_ok) begin
      nxt_s.aw_got = 1'b1;
      nxt_s.waddr  = awaddr;
    end
    if (w_ok) begin
      nxt_s.w_got = 1'b1;
      nxt_s.wdat  = wdata;
    end
    unique case (s.wst)
      pgw_pkg::WR_IDLE: begin
        if (nxt_s.aw_got && nxt_s.w_got) begin
          nxt_s.wst    = pgw_pkg::WR_RESP;
          nxt_s.aw_got = 1'b0;
          nxt_s.w_got  = 1'b0;
          nxt_s.bresp  = wr_bad ? pgw_pkg::RESP_ERR : pgw_pkg::RESP_OK;
          unique case (wa)
            pgw_pkg::OFS_A_OUT:  nxt_s.a_out  = wd[7:0];
            pgw_pkg::OFS_A_DIR:  nxt_s.a_dir  = wd[7:0];
            pgw_pkg::OFS_A_PULL: nxt_s.a_pull = wd[7:0];
            pgw_pkg::OFS_A_IEN:  nxt_s.a_ien  = wd[7:0];
            pgw_pkg::OFS_B_OUT:  nxt_s.b_out  = wd[6:0];
            pgw_pkg::OFS_B_DIR:  nxt_s.b_dir  = wd[6:0];
            pgw_pkg::OFS_B_PULL: nxt_s.b_pull = wd[6:0];
            pgw_pkg::OFS_B_IEN:  nxt_s.b_ien  = wd[6:0];
            pgw_pkg::OFS_C_OUT:  nxt_s.c_out  = wd[5:0];
            pgw_pkg::OFS_C_DIR:  nxt_s.c_dir  = wd[5:0];
            pgw_pkg::OFS_C_PULL: nxt_s.c_pull = wd[5:0];
            pgw_pkg::OFS_ALT:    nxt_s.alt    = wd[11:0];
            pgw_pkg::OFS_MSK:    nxt_s.msk    = wd[2:0];
            pgw_pkg::OFS_PWR:    nxt_s.pdn    = wd[0];
            pgw_pkg::OFS_ANA:    nxt_s.ana    = wd[9:0];
            default:             nxt_s.bresp  = nxt_s.bresp;
          endcase
        end
      end
      pgw_pkg::WR_RESP: begin
        if (bready) begin
          nxt_s.wst = pgw_pkg::WR_IDLE;
        end
      end
    endcase
    nxt_s.awrdy = (nxt_s.wst == pgw_pkg::WR_IDLE) && !nxt_s.aw_got;
    nxt_s.wrdy  = (nxt_s.wst == pgw_pkg::WR_IDLE) && !nxt_s.w_got;
    // Read channel; reading the status register clears what it returned.
    unique case (s.rst)
      pgw_pkg::RD_IDLE: begin
        if (arvalid) begin
          nxt_s.rst   = pgw_pkg::RD_DATA;
          nxt_s.rdat  = rd_val;
          nxt_s.rresp = rd_bad ? pgw_pkg::RESP_ERR : pgw_pkg::RESP_OK;
          if (araddr == pgw_pkg::OFS_STS) begin
            nxt_s.sts = s.sts & ~rd_val[2:0];
          end
        end
      end
      pgw_pkg::RD_DATA: begin
        if (rready) begin
          nxt_s.rst = pgw_pkg::RD_IDLE;
        end
      end
    endcase
    // Wake on any change of an enabled input while powered down.
    nxt_s.prev = gated;
    nxt_s.wake = s.pdn && (gated != s.prev);
    if (nxt_s.wake) begin
      nxt_s.pdn = 1'b0;
    end
    ev[pgw_pkg::STS_IRQ0] = hit0;
    ev[pgw_pkg::STS_IRQ1] = hit1;
    ev[pgw_pkg::STS_WAKE] = nxt_s.wake;
    nxt_s.sts  = nxt_s.sts | ev;
    nxt_s.irq  = |(nxt_s.sts & nxt_s.msk);
    nxt_s.irq0 = hit0;
    nxt_s.irq1 = hit1;
    // Ordinary pin drive.
    nxt_s.pa_o = s.a_out;
    nxt_s.pa_e = s.a_dir;
    nxt_s.pa_p = s.a_pull;
    nxt_s.pb_o = s.b_out;
    nxt_s.pb_e = s.b_dir;
    nxt_s.pb_p = s.b_pull;
    nxt_s.pc_o = s.c_out;
    nxt_s.pc_e = s.c_dir;
    nxt_s.pc_p = s.c_pull;
    nxt_s.bias = '0;
    // Port A bit five: open-drain, never pulled up, or reset input.
    nxt_s.pa_o[5] = 1'b0;
    nxt_s.pa_e[5] = s.a_dir[5] && !s.a_out[5] && !s.alt[pgw_pkg::ALT_RST];
    nxt_s.pa_p[5] = 1'b0;
    nxt_s.hwrst   = s.alt[pgw_pkg::ALT_RST] && !pin_s[5];
    // Crystal pins release the pads; their input enables are left to software.
    nxt_s.xtal = s.alt[pgw_pkg::ALT_XTAL];
    if (s.alt[pgw_pkg::ALT_XTAL]) begin
      nxt_s.pa_e[7:6] = 2'h0;
      nxt_s.pa_p[7:6] = 2'h0;
    end
    // Second timer PWM on port A bits two and three.
    if (s.alt[pgw_pkg::ALT_PWM2]) begin
      nxt_s.pa_o[2] = second_timer_pwm;
    end
    if (s.alt[pgw_pkg::ALT_PWM3]) begin
      nxt_s.pa_o[3] = second_timer_pwm;
    end
    // Analog channels release their pads.
    nxt_s.ana_o = s.ana;
    for (int k = 0; k < pgw_pkg::B_W; k++) begin
      if (s.ana[k]) begin
        nxt_s.pb_e[k] = 1'b0;
        nxt_s.pb_p[k] = 1'b0;
      end
    end
    if (s.ana[7]) begin
      nxt_s.pa_e[3] = 1'b0;
      nxt_s.pa_p[3] = 1'b0;
    end
    if (s.ana[8]) begin
      nxt_s.pa_e[4] = 1'b0;
      nxt_s.pa_p[4] = 1'b0;
    end
    if (s.ana[pgw_pkg::ANA_PC5]) begin
      nxt_s.pc_e[5] = 1'b0;
      nxt_s.pc_p[5] = 1'b0;
    end
    // LCD commons take priority over every other pad setting of their pins.
    for (int k = 0; k < 4; k++) begin
      if (s.alt[pgw_pkg::ALT_LCD+k]) begin
        nxt_s.bias[k] = lcd_common_half[k];
        unique case (k)
          0: begin
            nxt_s.pa_o[0] = lcd_common_drive[0];
            nxt_s.pa_e[0] = !lcd_common_half[0];
            nxt_s.pa_p[0] = 1'b0;
          end
          1: begin
            nxt_s.pc_o[5] = lcd_common_drive[1];
            nxt_s.pc_e[5] = !lcd_common_half[1];
            nxt_s.pc_p[5] = 1'b0;
          end
          2: begin
            nxt_s.pa_o[2] = lcd_common_drive[2];
            nxt_s.pa_e[2] = !lcd_common_half[2];
            nxt_s.pa_p[2] = 1'b0;
          end
          default: begin
            nxt_s.pa_o[3] = lcd_common_drive[3];
            nxt_s.pa_e[3] = !lcd_common_half[3];
            nxt_s.pa_p[3] = 1'b0;
          end
        endcase
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // State register.
  always_ff @(posedge clk) begin
    if (srst) begin
      s       <= '0;
      s.wst   <= pgw_pkg::WR_IDLE;
      s.rst   <= pgw_pkg::RD_IDLE;
      s.awrdy <= 1'b1;
      s.wrdy  <= 1'b1;
      s.a_ien <= pgw_pkg::RST_A_IEN;
      s.b_ien <= pgw_pkg::RST_B_IEN;
    end else begin
      s <= nxt_s;
    end
  end

  assign awready           = s.awrdy;
  assign wready            = s.wrdy;
  assign bvalid            = s.wst[1];
  assign bresp             = s.bresp;
  assign arready           = s.rst[0];
  assign rvalid            = s.rst[1];
  assign rdata             = s.rdat;
  assign rresp             = s.rresp;
  assign pa_out            = s.pa_o;
  assign pa_oe             = s.pa_e;
  assign pa_pull           = s.pa_p;
  assign pb_out            = s.pb_o;
  assign pb_oe             = s.pb_e;
  assign pb_pull           = s.pb_p;
  assign pc_out            = s.pc_o;
  assign pc_oe             = s.pc_e;
  assign pc_pull           = s.pc_p;
  assign lcd_bias_en       = s.bias;
  assign analog_chan_en    = s.ana_o;
  assign crystal_en        = s.xtal;
  assign hw_reset_req      = s.hwrst;
  assign ext_irq_line_zero = s.irq0;
  assign ext_irq_line_one  = s.irq1;
  assign wake_req          = s.wake;
  assign power_down        = s.pdn;
  assign irq               = s.irq;

  //////////////////////////////////////////////////////////////////////////////
  // Assertions.
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  a_a_gate_in: assert property (##1 (s.prev[7:0] & ~$past(s.a_ien)) == 8'h0)
    else $error("Disabled port A input seen.");
  a_b_gate_in: assert property (##1 (s.prev[14:8] & ~$past(s.b_ien)) == 7'h0)
    else $error("Disabled port B input seen.");
  a_pa5_nopull: assert property (!pa_pull[5] && !pa_out[5])
    else $error("Port A bit five pulled or driven high.");
  a_pa5_od: assert property (pa_oe[5] |-> $past(s.a_dir[5] && !s.a_out[5]))
    else $error("Port A bit five enabled without low output.");
  a_irq0_edge: assert property (($rose(gated[0]) && s.alt[pgw_pkg::ALT_I0EN] && s.alt[pgw_pkg::ALT_I0RI]
    && $stable(s.alt)) |-> ##2 (ext_irq_line_zero && s.sts[pgw_pkg::STS_IRQ0]))
    else $error("Rising edge on line zero missed.");
  a_adc_pin: assert property ($past(s.ana[8] && !s.alt[pgw_pkg::ALT_LCD+3]) |-> !pa_oe[4])
    else $error("Analog channel eight pin driven.");
  a_pwm_route: assert property ($past(s.alt[pgw_pkg::ALT_PWM2] && !s.alt[pgw_pkg::ALT_LCD+2])
    |-> pa_out[2] == $past(second_timer_pwm))
    else $error("PWM not on port A bit two.");
  a_lcd_bias: assert property ($past(s.alt[pgw_pkg::ALT_LCD+3] && lcd_common_half[3])
    |-> lcd_bias_en[3] && !pa_oe[3])
    else $error("Half bias not given on common three.");
  a_pc5_analog: assert property ($past(s.ana[pgw_pkg::ANA_PC5] && !s.alt[pgw_pkg::ALT_LCD+1]) |-> !pc_oe[5])
    else $error("Analog port C bit five driven.");
  a_wake_rise: assert property ((s.pdn && gated != s.prev) |=> wake_req && !power_down)
    else $error("Wake not raised on input change.");
  a_wake_quiet: assert property ((s.pdn && gated == s.prev) |=> !wake_req)
    else $error("Wake raised without enabled change.");

  c_wake: cover property (s.pdn ##1 wake_req);
  c_irq1: cover property (ext_irq_line_one && s.sts[pgw_pkg::STS_IRQ1]);
  c_sts_read: cover property (rd_hit && araddr == pgw_pkg::OFS_STS && s.sts != 3'h0);
endmodule

/* hdl/pgw_pkg.sv */
// Constants for the general-purpose port block: register map, field positions and reset values.
// Assumes a 32-bit AXI4-Lite register bus and one system clock.
package pgw_pkg;
  localparam int ADDR_W = 7;
  localparam int A_W    = 8;
  localparam int B_W    = 7;
  localparam int C_W    = 6;
  localparam int PIN_W  = A_W + B_W + C_W;
  localparam int ANA_W  = 10;
  localparam int ALT_W  = 12;
  localparam int STS_W  = 3;

  localparam logic [ADDR_W-1:0] OFS_A_OUT  = 7'h00;
  localparam logic [ADDR_W-1:0] OFS_A_DIR  = 7'h04;
  localparam logic [ADDR_W-1:0] OFS_A_PULL = 7'h08;
  localparam logic [ADDR_W-1:0] OFS_A_IEN  = 7'h0c;
  localparam logic [ADDR_W-1:0] OFS_A_IN   = 7'h10;
  localparam logic [ADDR_W-1:0] OFS_B_OUT  = 7'h14;
  localparam logic [ADDR_W-1:0] OFS_B_DIR  = 7'h18;
  localparam logic [ADDR_W-1:0] OFS_B_PULL = 7'h1c;
  localparam logic [ADDR_W-1:0] OFS_B_IEN  = 7'h20;
  localparam logic [ADDR_W-1:0] OFS_B_IN   = 7'h24;
  localparam logic [ADDR_W-1:0] OFS_C_OUT  = 7'h28;
  localparam logic [ADDR_W-1:0] OFS_C_DIR  = 7'h2c;
  localparam logic [ADDR_W-1:0] OFS_C_PULL = 7'h30;
  localparam logic [ADDR_W-1:0] OFS_C_IN   = 7'h34;
  localparam logic [ADDR_W-1:0] OFS_ALT    = 7'h38;
  localparam logic [ADDR_W-1:0] OFS_STS    = 7'h3c;
  localparam logic [ADDR_W-1:0] OFS_MSK    = 7'h40;
  localparam logic [ADDR_W-1:0] OFS_PWR    = 7'h44;
  localparam logic [ADDR_W-1:0] OFS_ANA    = 7'h48;

  // Alternate function control fields.
  localparam int ALT_XTAL  = 0;
  localparam int ALT_RST   = 1;
  localparam int ALT_PWM2  = 2;
  localparam int ALT_PWM3  = 3;
  localparam int ALT_LCD   = 4;
  localparam int ALT_I0EN  = 8;
  localparam int ALT_I0RI  = 9;
  localparam int ALT_I1EN  = 10;
  localparam int ALT_I1RI  = 11;
  // Status and mask fields.
  localparam int STS_IRQ0  = 0;
  localparam int STS_IRQ1  = 1;
  localparam int STS_WAKE  = 2;
  // Analog field that belongs to port C bit 5.
  localparam int ANA_PC5   = 9;

  localparam logic [A_W-1:0]   RST_A_IEN = 8'hff;
  localparam logic [B_W-1:0]   RST_B_IEN = 7'h7f;
  localparam logic [1:0]       RESP_OK   = 2'h0;
  localparam logic [1:0]       RESP_ERR  = 2'h2;

  typedef enum logic [1:0] {WR_IDLE = 2'b01, WR_RESP = 2'b10} pgw_wr_e;
  typedef enum logic [1:0] {RD_IDLE = 2'b01, RD_DATA = 2'b10} pgw_rd_e;
endpackage

/* hdl/pgw_sync.sv */
// Two-stage synchroniser for a vector of pin inputs.
// Assumes the inputs are asynchronous to clk; only the second stage is read.
`timescale 1ns/100ps
module pgw_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         srst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } pgw_sync_s;

  pgw_sync_s s;
  pgw_sync_s nxt_s;

  always_comb begin
    nxt_s    = s;
    nxt_s.s1 = d;
    nxt_s.s2 = s.s1;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      s <= '0;
    end else begin
      s <= nxt_s;
    end
  end

  assign q = s.s2;
endmodule

/* hdl/pgw_edge.sv */
// Edge detector for one external interrupt line with a selectable edge.
// Assumes the input is already on the clk domain.
`timescale 1ns/100ps
module pgw_edge (
  input  wire logic clk,
  input  wire logic srst,
  input  wire logic sig,
  input  wire logic en,
  input  wire logic rise_sel,
  output logic      hit
);
  typedef struct packed {
    logic prev;
    logic hit;
  } pgw_edge_s;

  pgw_edge_s s;
  pgw_edge_s nxt_s;

  always_comb begin
    nxt_s      = s;
    nxt_s.prev = sig;
    nxt_s.hit  = en && (rise_sel ? (sig && !s.prev) : (!sig && s.prev));
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      s <= '0;
    end else begin
      s <= nxt_s;
    end
  end

  assign hit = s.hit;
endmodule

/* dv/pgw_pad.sv */
// Board model for one port: external drivers, pull-ups and floating pins.
// Assumes the port's pad controls on clk; a floating pin changes every cycle.
`timescale 1ns/100ps
module pgw_pad #(
  parameter int W = 8
) (
  input  wire logic         clk,
  input  wire logic [W-1:0] out,
  input  wire logic [W-1:0] oe,
  input  wire logic [W-1:0] pull,
  input  wire logic [W-1:0] ext,
  input  wire logic [W-1:0] ext_en,
  output logic      [W-1:0] pin
);
  logic [W-1:0] flt = '0;
  always @(posedge clk) flt <= ~flt;
  // The pad wins, then the board driver, then the pull-up, else the pin floats.
  always_comb begin
    for (int i = 0; i < W; i++) begin
      pin[i] = oe[i] ? out[i] : ext_en[i] ? ext[i] : pull[i] ? 1'b1 : flt[i];
    end
  end
endmodule

/* dv/pgw_port_tb.sv */
// Self-checking bench for the port block, a board model on each port.
// Assumes one 125 MHz clock and a synchronous active-high reset.
`timescale 1ns/100ps
module pgw_port_tb;
  logic        clk = 1'b0, srst = 1'b1, pwm = 1'b0;
  logic [6:0]  awaddr = '0, araddr = '0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = '0, rdata, rd, v, m, e;
  logic [1:0]  bresp, rresp, rs, bq;
  logic        awready, wready, bvalid, arready, rvalid, crystal_en, hw_reset_req;
  logic        ext_irq_line_zero, ext_irq_line_one, wake_req, power_down, irq;
  logic [7:0]  pa_in, pa_out, pa_oe, pa_pull, xa = '0, xa_en = '1;
  logic [6:0]  pb_in, pb_out, pb_oe, pb_pull, xb = '0, xb_en = '1;
  logic [5:0]  pc_in, pc_out, pc_oe, pc_pull, xc = '0, xc_en = '1;
  logic [3:0]  lcd_bias_en, lcd_drv = '0, lcd_half = '0;
  logic [9:0]  analog_chan_en;
  int          n_mismatch = 0, n_checks = 0, n_wake = 0, n_irq = 0;
  int          mdl[int];
  pgw_port u_dut (.clk, .srst, .awaddr, .awvalid, .awready, .wdata, .wstrb(4'hf), .wvalid, .wready, .bresp,
    .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .pa_in, .pa_out, .pa_oe,
    .pa_pull, .pb_in, .pb_out, .pb_oe, .pb_pull, .pc_in, .pc_out, .pc_oe, .pc_pull, .second_timer_pwm(pwm),
    .lcd_common_drive(lcd_drv), .lcd_common_half(lcd_half), .lcd_bias_en, .analog_chan_en, .crystal_en,
    .hw_reset_req, .ext_irq_line_zero, .ext_irq_line_one, .wake_req, .power_down, .irq);
  pgw_pad #(.W(8)) u_pa (.clk, .out(pa_out), .oe(pa_oe), .pull(pa_pull), .ext(xa), .ext_en(xa_en), .pin(pa_in));
  pgw_pad #(.W(7)) u_pb (.clk, .out(pb_out), .oe(pb_oe), .pull(pb_pull), .ext(xb), .ext_en(xb_en), .pin(pb_in));
  pgw_pad #(.W(6)) u_pc (.clk, .out(pc_out), .oe(pc_oe), .pull(pc_pull), .ext(xc), .ext_en(xc_en), .pin(pc_in));
  always #4 clk = ~clk;
  always @(posedge clk) if (wake_req === 1'b1) n_wake++;
  always @(posedge clk) n_irq += (ext_irq_line_zero === 1'b1) + 16 * (ext_irq_line_one === 1'b1);
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [31:0] d);
    int n = 0;
    if (a != pgw_pkg::OFS_PWR) mdl[a] = d;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      n++;
    end while (!bvalid && n < 64);
    if (n == 64) n_mismatch++;
    bq = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd_reg(input logic [6:0] a, output logic [31:0] d, output logic [1:0] r);
    int n = 0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
      n++;
    end while (!rvalid && n < 64);
    if (n == 64) n_mismatch++;
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  task automatic setp(input int l, input logic b);
    if (l == 0) xa[0] <= b;
    else xb[0] <= b;
    repeat (6) @(posedge clk);
  endtask
  task automatic results;
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #200000;
    n_mismatch++;
    results();
  end
  initial begin
    v = $urandom(44);
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    rd_reg(pgw_pkg::OFS_A_IEN, rd, rs);
    chk(rd, 32'hff);
    rd_reg(pgw_pkg::OFS_B_IEN, rd, rs);
    chk(rd, 32'h7f);
    rd_reg(7'h7c, rd, rs);
    chk(32'(rs), 32'(pgw_pkg::RESP_ERR));
    wr(7'h7c, 32'h1);
    mdl.delete(7'h7c);
    chk(32'(bq), 32'(pgw_pkg::RESP_ERR));
    for (int i = 0; i < 4; i++) begin
      v = $urandom;
      m = $urandom;
      xa <= v[7:0];
      xb <= v[14:8];
      wr(pgw_pkg::OFS_A_IEN, 32'(m[7:0]));
      wr(pgw_pkg::OFS_B_IEN, 32'(m[14:8]));
      repeat (4) @(posedge clk);
      rd_reg(pgw_pkg::OFS_A_IN, rd, rs);
      chk(rd, 32'(v[7:0] & m[7:0]));
      rd_reg(pgw_pkg::OFS_B_IN, rd, rs);
      chk(rd, 32'(v[14:8] & m[14:8]));
    end
    wr(pgw_pkg::OFS_A_OUT, 32'(v[7:0]));
    wr(pgw_pkg::OFS_A_DIR, 32'(m[7:0]));
    wr(pgw_pkg::OFS_A_PULL, 32'(v[15:8]));
    repeat (2) @(posedge clk);
    chk(32'(pa_oe), 32'(m[7:0] & ~(8'h20 & v[7:0])));
    chk(32'(pa_out), 32'(v[7:0] & 8'hdf));
    chk(32'(pa_pull), 32'(v[15:8] & 8'hdf));
    wr(pgw_pkg::OFS_ALT, 32'hc);
    for (int k = 0; k < 2; k++) begin
      pwm <= k[0];
      repeat (3) @(posedge clk);
      chk(32'(pa_out[3:2]), 32'(k[0] ? 2'b11 : 2'b00));
    end
    wr(pgw_pkg::OFS_ALT, 32'h0);
    wr(pgw_pkg::OFS_A_DIR, 32'h0);
    wr(pgw_pkg::OFS_A_PULL, 32'hff);
    wr(pgw_pkg::OFS_A_IEN, 32'hff);
    wr(pgw_pkg::OFS_B_IEN, 32'h7f);
    xa_en <= '0;
    repeat (4) @(posedge clk);
    rd_reg(pgw_pkg::OFS_A_IN, rd, rs);
    chk(rd & 32'hdf, 32'hdf);
    xa_en <= '1;
    for (int l = 0; l < 2; l++) begin
      e = 32'($urandom % 2);
      setp(l, !e[0]);
      wr(pgw_pkg::OFS_MSK, 32'(l == 0));
      wr(pgw_pkg::OFS_ALT, (32'h100 << (2 * l)) | (e << (9 + 2 * l)));
      rd_reg(pgw_pkg::OFS_STS, rd, rs);
      n_irq = 0;
      setp(l, e[0]);
      chk(32'(irq), 32'(l == 0));
      rd_reg(pgw_pkg::OFS_STS, rd, rs);
      chk(rd, 32'h1 << l);
      repeat (2) @(posedge clk);
      chk(32'(irq), 32'h0);
      setp(l, !e[0]);
      rd_reg(pgw_pkg::OFS_STS, rd, rs);
      chk(rd, 32'h0);
      chk(32'(n_irq), 32'h1 << (4 * l));
    end
    wr(pgw_pkg::OFS_ALT, 32'h0);
    wr(pgw_pkg::OFS_A_IEN, 32'hfb);
    wr(pgw_pkg::OFS_PWR, 32'h1);
    n_wake = 0;
    xa[2] <= ~xa[2];
    repeat (6) @(posedge clk);
    chk(32'(power_down), 32'h1);
    xa[0] <= ~xa[0];
    repeat (6) @(posedge clk);
    chk(32'(power_down), 32'h0);
    chk(32'(n_wake), 32'h1);
    rd_reg(pgw_pkg::OFS_STS, rd, rs);
    chk(rd & 32'h4, 32'h4);
    v = $urandom;
    wr(pgw_pkg::OFS_ANA, 32'(v[9:0]));
    repeat (2) @(posedge clk);
    chk(32'(analog_chan_en), 32'(v[9:0]));
    v = $urandom;
    lcd_drv <= v[3:0];
    lcd_half <= v[7:4];
    xa[5] <= 1'b0;
    wr(pgw_pkg::OFS_ALT, 32'hf3);
    repeat (2) @(posedge clk);
    chk(32'(lcd_bias_en), 32'(v[7:4]));
    chk(32'({pc_out[5], pc_oe[5], pa_out[3:2], pa_out[0]}), 32'({v[1], !v[5], v[3:2], v[0]}));
    chk(32'({pa_oe[3:2], pa_oe[0]} ^ {v[7:6], v[4]}), 32'h7);
    chk(32'({crystal_en, hw_reset_req, pa_pull[7:5]}), 32'h18);
    foreach (mdl[a]) begin
      rd_reg(7'(a), rd, rs);
      chk(rd, 32'(mdl[a]));
    end
    results();
  end
endmodule
